/* endpoint_descriptor_decoder_tb.sv */
// testbench of the endpoint descriptor decoder with a host reading it back
`timescale 1ns/1ns
module endpoint_descriptor_decoder_tb;
   logic clock, rstn, build, ep_in, cfg_read, check_en, go;
   logic [3:0] ep_num;
   logic [1:0] xfer, sync, usage, mult, speed, rx, rsp;
   logic [10:0] max_pkt;
   logic [7:0] interval, rd_byte;
   logic [2:0] rd_ofs;
   logic [55:0] check_desc;
   logic rd_valid, built, desc_err, check_done, check_err, never_nak;
   logic [31:0] period_cyc;
   logic [7:0] byte_q[$];
   logic err_q[$];
   int fail_count, compares;
   // ===========================================
   // clock, design and host
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   ep_desc_decoder DUT (.clock(clock), .rstn(rstn), .build(build), .ep_num(ep_num),
      .ep_in(ep_in), .xfer(xfer), .sync(sync), .usage(usage), .max_pkt(max_pkt), .mult(mult),
      .interval(interval), .speed(speed), .cfg_read(cfg_read), .rd_ofs(rd_ofs),
      .check_en(check_en), .check_desc(check_desc), .rd_valid(rd_valid), .rd_byte(rd_byte),
      .built(built), .desc_err(desc_err), .check_done(check_done), .check_err(check_err),
      .period_cyc(period_cyc), .never_nak(never_nak));
   ep_host_model host (.clock(clock), .rstn(rstn), .go(go), .cfg_read(cfg_read),
      .rd_ofs(rd_ofs));
   // ===========================================
   // checking
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // compare each served byte and each check verdict with the oldest note
   always @(posedge clock) begin
      #1;
      if (rd_valid !== 1'b0) begin
         if (byte_q.size() == 0) check(rd_valid, 1'b0);
         else check(rd_byte, byte_q.pop_front());
      end
      if (check_done === 1'b1) begin
         if (err_q.size() == 0) check(check_done, 1'b0);
         else check(check_err, err_q.pop_front());
      end
   end
   // ===========================================
   // stimulus tasks
   task automatic read_back();
      @(negedge clock);
      go <= 1'b1;
      @(negedge clock);
      go <= 1'b0;
      repeat (12) @(negedge clock);
      check(byte_q.size(), 0);
   endtask
   task automatic drive_check(input logic [55:0] dsc, input logic exp);
      @(negedge clock);
      check_desc = dsc;
      check_en = 1'b1;
      err_q.push_back(exp);
      @(negedge clock);
      check_en = 1'b0;
   endtask
   task automatic run_case(input logic [3:0] e, input logic d, input logic [1:0] x, s, u, mu,
         sp, input logic [10:0] m, input logic [7:0] iv);
      logic [55:0] dsc;
      logic iso, hsp, err;
      logic [31:0] unit, per;
      iso = (x == ep_desc_pkg::XFER_ISO);
      hsp = (sp == 2'h2) && x[0];
      dsc = {iv, 3'h0, hsp ? mu : 2'h0, m, 2'h0, iso ? u : 2'h0, iso ? s : 2'h0, x, d, 3'h0, e,
         ep_desc_pkg::DESC_TYPE_EP, ep_desc_pkg::DESC_LEN};
      err = (m == 11'h000) || (m > 11'h400) || (iso && u == 2'h3)
         || (iso && u == 2'h1 && s != 2'h0) || (hsp && (mu == 2'h3
         || (mu == 2'h1 && m < 11'h201) || (mu == 2'h2 && m < 11'h2ab)))
         || (x[0] && iv == 8'h00) || (x[0] && iv > 8'h10 && (iso || sp == 2'h2));
      unit = (sp == 2'h2) ? ep_desc_pkg::UFRAME_CYC : ep_desc_pkg::FRAME_CYC;
      if (iso || hsp) per = (iv >= 8'h01 && iv <= 8'h10) ? unit << (iv - 8'h01) : '0;
      else per = iv * unit;
      @(negedge clock);
      {ep_num, ep_in, xfer, sync, usage, mult, speed, max_pkt, interval} =
         {e, d, x, s, u, mu, sp, m, iv};
      build = 1'b1;
      @(negedge clock);
      build = 1'b0;
      @(negedge clock);
      check(built, e != 4'h0);
      if (e != 4'h0) begin
         check(desc_err, err);
         check(period_cyc, per);
         check(never_nak, (sp == 2'h2) && !x[0] && !d && iv == 8'h00);
         for (int i = 0; i < 7; i++) byte_q.push_back(dsc[8*i +: 8]);
      end else begin
         check(desc_err, 1'b1);
      end
      read_back();
      if (e != 4'h0) begin
         drive_check(dsc, err);
         drive_check(dsc | (56'h1 << 20), 1'b1);
         drive_check(dsc | (56'h1 << 45), 1'b1);
         drive_check(dsc | (56'h1 << 31), err);
      end
      $display("case ep %0d xfer %0d speed %0d done", e, x, sp);
   endtask
   // ===========================================
   // main sequence
   initial begin
      {rstn, build, ep_num, ep_in, xfer, sync, usage, mult, speed, max_pkt, interval} = '0;
      {check_en, check_desc, go, rx, rsp} = '0;
      void'($urandom(32'hdba6_e53c));
      repeat (5) @(negedge clock);
      rstn = 1'b1;
      read_back();
      run_case(4'h1, 1'b0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h2, 11'h200, 8'h00);
      run_case(4'h2, 1'b1, 2'h3, 2'h0, 2'h0, 2'h0, 2'h1, 11'h040, 8'hff);
      run_case(4'h3, 1'b1, 2'h3, 2'h0, 2'h0, 2'h2, 2'h2, 11'h400, 8'h10);
      run_case(4'h4, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 11'h040, 8'h04);
      run_case(4'h0, 1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 11'h040, 8'h00);
      run_case(4'h5, 1'b0, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 11'h008, 8'h0a);
      for (int s = 0; s < 4; s++) run_case(4'h6, 1'b1, 2'h1, 2'(s), 2'h0, 2'h1, 2'h2,
         11'h201, 8'h01);
      for (int u = 0; u < 4; u++) run_case(4'h7, 1'b0, 2'h1, 2'h0, 2'(u), 2'h0, 2'h1,
         11'h3ff, 8'h04);
      run_case(4'h8, 1'b1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h1, 11'h100, 8'h01);
      run_case(4'h9, 1'b0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2, 11'h100, 8'h11);
      run_case(4'ha, 1'b1, 2'h3, 2'h0, 2'h0, 2'h1, 2'h2, 11'h200, 8'h01);
      run_case(4'hb, 1'b1, 2'h3, 2'h0, 2'h0, 2'h3, 2'h2, 11'h400, 8'h01);
      run_case(4'hc, 1'b0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h1, 11'h000, 8'h00);
      run_case(4'hd, 1'b1, 2'h3, 2'h0, 2'h0, 2'h0, 2'h1, 11'h040, 8'h00);
      repeat (30) begin
         rx = 2'($urandom);
         rsp = (rx == 2'h1) ? 2'h1 + 2'($urandom % 2) : 2'($urandom % 3);
         run_case(4'($urandom % 15 + 1), (rx != 2'h0) & 1'($urandom), rx, 2'($urandom),
            2'($urandom), (rsp == 2'h2 && rx[0]) ? 2'($urandom % 3) : 2'h0, rsp,
            11'($urandom % 1024 + 1), 8'($urandom));
      end
      @(negedge clock);
      rstn = 1'b0;
      @(negedge clock);
      rstn = 1'b1;
      check(built, 1'b0);
      read_back();
      finish_test();
   end
   // cut a hang short
   initial begin
      #500000;
      fail_count++;
      finish_test();
   end
endmodule // endpoint_descriptor_decoder_tb

/* ep_desc_decoder.sv */
// endpoint descriptor builder, byte server and checker
// How it works
// - bytes served only while the configuration data is being returned
// - endpoint number zero gives no descriptor and flags an error
// - bytes 0..6 are length, type, address, attributes, packet size, interval
// - address: bits 3..0 number, 6..4 zero, bit 7 direction
// - attribute bits 1..0 hold transfer type
// - non-isochronous endpoints get attribute bits 5..2 forced to zero
// - isochronous attribute bits 3..2 hold synchronization type
// - attribute bits 7..6 driven zero, ignored when checked
// - packet size bits 10..0 carry the largest packet in bytes
// - high speed periodic: bits 12..11 extra transactions, 11 reserved
// - packet size bits 15..13 driven zero
// - interval unit is a frame or microframe by speed, given as cycles
// - isochronous interval 1..16, period two to interval minus one
// - full/low speed interrupt interval 1..255
// - high speed interrupt interval 1..16, power of two period
// - high speed bulk/control OUT interval is the NAK rate, zero never
// - two transactions need 513..1024 bytes, three need 683..1024
// - explicit feedback must be isochronous with no synchronization
`timescale 1ns/1ns
module ep_desc_decoder #(
   parameter int MPS_BITS = 11
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic build,
   input wire logic [3:0] ep_num,
   input wire logic ep_in,
   input wire logic [1:0] xfer,
   input wire logic [1:0] sync,
   input wire logic [1:0] usage,
   input wire logic [10:0] max_pkt,
   input wire logic [1:0] mult,
   input wire logic [7:0] interval,
   input wire logic [1:0] speed,
   input wire logic cfg_read,
   input wire logic [2:0] rd_ofs,
   input wire logic check_en,
   input wire logic [55:0] check_desc,
   output logic rd_valid,
   output logic [7:0] rd_byte,
   output logic built,
   output logic desc_err,
   output logic check_done,
   output logic check_err,
   output logic [31:0] period_cyc,
   output logic never_nak
);
   // refuse a packet size field width that the byte layout cannot hold
   if (MPS_BITS != 11) begin : g_bad_mps
      $error("packet size field must be 11 bits");
   end

   // ==========================================================
   // field checking shared by build and decode
   // ==========================================================
   function automatic logic desc_bad(input logic [55:0] d, input logic [1:0] spd);
      logic [7:0] a;
      logic [7:0] t;
      logic [15:0] m;
      logic [7:0] iv;
      logic hs;
      logic bad;
      a = d[8*ep_desc_pkg::OFS_ADDR +: 8];
      t = d[8*ep_desc_pkg::OFS_ATTR +: 8];
      m = d[8*ep_desc_pkg::OFS_MPS_LO +: 16];
      iv = d[8*ep_desc_pkg::OFS_INTERVAL +: 8];
      hs = (spd == 2'(ep_desc_pkg::SPEED_HIGH));
      bad = 1'b0;
      if (d[7:0] != ep_desc_pkg::DESC_LEN) bad = 1'b1;
      if (d[15:8] != ep_desc_pkg::DESC_TYPE_EP) bad = 1'b1;
      if (a[3:0] == 4'h0) bad = 1'b1;
      if (a[6:4] != 3'h0) bad = 1'b1;
      if (m[15:13] != 3'h0) bad = 1'b1;
      if (m[10:0] == 11'h000 || m[10:0] > ep_desc_pkg::MPS_MAX_HB) bad = 1'b1;
      if (t[1:0] != ep_desc_pkg::XFER_ISO && t[5:2] != 4'h0) bad = 1'b1;
      if (t[1:0] == ep_desc_pkg::XFER_ISO && t[5:4] == ep_desc_pkg::USAGE_RSVD) bad = 1'b1;
      if (t[5:4] == ep_desc_pkg::USAGE_FEEDBACK && t[3:2] != ep_desc_pkg::SYNC_NONE)
         bad = 1'b1;
      if (hs && (t[1:0] == ep_desc_pkg::XFER_ISO || t[1:0] == ep_desc_pkg::XFER_INTR)) begin
         if (m[12:11] == ep_desc_pkg::MULT_RSVD) bad = 1'b1;
         if (m[12:11] == ep_desc_pkg::MULT_TWO && m[10:0] < ep_desc_pkg::MPS_MIN_TWO)
            bad = 1'b1;
         if (m[12:11] == ep_desc_pkg::MULT_THREE && m[10:0] < ep_desc_pkg::MPS_MIN_THREE)
            bad = 1'b1;
      end else if (m[12:11] != 2'h0) begin
         bad = 1'b1;
      end
      if (t[1:0] == ep_desc_pkg::XFER_ISO) begin
         if (iv < ep_desc_pkg::IVL_MIN || iv > ep_desc_pkg::IVL_MAX_EXP) bad = 1'b1;
      end else if (t[1:0] == ep_desc_pkg::XFER_INTR) begin
         if (iv < ep_desc_pkg::IVL_MIN) bad = 1'b1;
         if (hs && iv > ep_desc_pkg::IVL_MAX_EXP) bad = 1'b1;
      end
      // bits 7..6 of attributes are not checked: these reserved bits are ignored
      return bad;
   endfunction

   // period in clock cycles for a given interval field
   function automatic logic [31:0] period_of(input logic [7:0] t, input logic [7:0] iv,
                                             input logic [1:0] spd);
      logic [31:0] unit;
      logic [31:0] p;
      unit = (spd == 2'(ep_desc_pkg::SPEED_HIGH)) ? 32'(ep_desc_pkg::UFRAME_CYC)
                                                    : 32'(ep_desc_pkg::FRAME_CYC);
      p = 32'h0000_0000;
      if (t[1:0] == ep_desc_pkg::XFER_ISO ||
          (t[1:0] == ep_desc_pkg::XFER_INTR && spd == 2'(ep_desc_pkg::SPEED_HIGH))) begin
         if (iv >= ep_desc_pkg::IVL_MIN && iv <= ep_desc_pkg::IVL_MAX_EXP)
            p = unit << (iv - ep_desc_pkg::IVL_MIN);
      end else begin
         p = unit * 32'(iv);
      end
      return p;
   endfunction

   // ==========================================================
   // descriptor assembly
   // ==========================================================
   logic [7:0] attr_c;
   logic [15:0] mps_c;
   logic [55:0] desc_c;
   logic hs_periodic;
   always_comb begin
      hs_periodic = (speed == 2'(ep_desc_pkg::SPEED_HIGH)) &&
                    (xfer == ep_desc_pkg::XFER_ISO || xfer == ep_desc_pkg::XFER_INTR);
      attr_c = {2'h0, 4'h0, xfer};
      if (xfer == ep_desc_pkg::XFER_ISO) begin
         attr_c[5:2] = {usage, sync};
      end
      // otherwise bits 5..2 stay zero
      mps_c = {3'h0, (hs_periodic ? mult : 2'h0), max_pkt};
      desc_c = {interval, mps_c, attr_c, ep_in, 3'h0, ep_num,
                ep_desc_pkg::DESC_TYPE_EP, ep_desc_pkg::DESC_LEN};
   end

   ep_desc_if bus ();
   logic wr_q;
   logic [55:0] wr_desc_q;
   ep_desc_store u_store (
      .clock(clock),
      .rstn(rstn),
      .wr_en(wr_q),
      .wr_desc(wr_desc_q),
      .port(bus)
   );

   // register a build request; endpoint zero is never stored
   always_ff @(posedge clock) begin
      if (!rstn) begin
         wr_q <= 1'b0;
         wr_desc_q <= 56'h0000_0000_0000_00;
      end else begin
         wr_q <= build && (ep_num != 4'h0);
         wr_desc_q <= desc_c;
      end
   end

   // build status
   always_ff @(posedge clock) begin
      if (!rstn) begin
         built <= 1'b0;
         desc_err <= 1'b0;
         period_cyc <= 32'h0000_0000;
         never_nak <= 1'b0;
      end else if (build) begin
         built <= (ep_num != 4'h0);
         desc_err <= desc_bad(desc_c, speed);
         period_cyc <= period_of(attr_c, interval, speed);
         never_nak <= (speed == 2'(ep_desc_pkg::SPEED_HIGH)) && !ep_in &&
                      (xfer == ep_desc_pkg::XFER_BULK || xfer == ep_desc_pkg::XFER_CONTROL) &&
                      (interval == 8'h00);
      end
   end

   // ==========================================================
   // byte serving within configuration data only
   // ==========================================================
   logic req_q;
   assign bus.addr = rd_ofs;
   always_ff @(posedge clock) begin
      if (!rstn) begin
         req_q <= 1'b0;
      end else begin
         req_q <= cfg_read && built && (rd_ofs <= ep_desc_pkg::OFS_LAST);
      end
   end
   always_ff @(posedge clock) begin
      if (!rstn) begin
         rd_valid <= 1'b0;
         rd_byte <= 8'h00;
      end else begin
         rd_valid <= req_q;
         rd_byte <= req_q ? bus.rdata : 8'h00;
      end
   end

   // ==========================================================
   // decoding of a received descriptor
   // ==========================================================
   always_ff @(posedge clock) begin
      if (!rstn) begin
         check_done <= 1'b0;
         check_err <= 1'b0;
      end else begin
         check_done <= check_en;
         if (check_en) check_err <= desc_bad(check_desc, speed);
      end
   end

   // ==========================================================
   // assertions
   // ==========================================================
   a_serve_needs_request: assert property (@(posedge clock) disable iff (!rstn)
      rd_valid |-> $past(cfg_read, 2))
      else $error("byte served outside configuration read");
   a_no_ep_zero: assert property (@(posedge clock) disable iff (!rstn)
      build && ep_num == 4'h0 |=> !built)
      else $error("endpoint zero descriptor built");
   a_zero_flagged: assert property (@(posedge clock) disable iff (!rstn)
      build && ep_num == 4'h0 |=> desc_err)
      else $error("endpoint zero build not flagged");
   // every accepted offset is answered two cycles later, others never
   a_serve_latency: assert property (@(posedge clock) disable iff (!rstn)
      cfg_read && built && rd_ofs <= ep_desc_pkg::OFS_LAST |-> ##2 rd_valid)
      else $error("requested byte not served");
   a_past_end_refused: assert property (@(posedge clock) disable iff (!rstn)
      cfg_read && rd_ofs > ep_desc_pkg::OFS_LAST |-> ##2 !rd_valid)
      else $error("offset past descriptor served");
   a_idle_byte_zero: assert property (@(posedge clock) disable iff (!rstn)
      !rd_valid |-> rd_byte == 8'h00)
      else $error("byte shown while not serving");
   a_dir_bit: assert property (@(posedge clock) disable iff (!rstn)
      build && ep_num != 4'h0 |=> wr_q && wr_desc_q[23] == $past(ep_in))
      else $error("direction bit not stored");
   a_attr_top_zero: assert property (@(posedge clock) disable iff (!rstn)
      wr_q |-> wr_desc_q[31:30] == 2'h0)
      else $error("attribute top bits set");
   a_mult_forced_zero: assert property (@(posedge clock) disable iff (!rstn)
      build && (speed != 2'(ep_desc_pkg::SPEED_HIGH) || xfer == ep_desc_pkg::XFER_BULK ||
      xfer == ep_desc_pkg::XFER_CONTROL) |=> wr_desc_q[44:43] == 2'h0)
      else $error("extra transactions outside high speed periodic");
   a_nak_full_speed: assert property (@(posedge clock) disable iff (!rstn)
      build && speed != 2'(ep_desc_pkg::SPEED_HIGH) |=> !never_nak)
      else $error("nak rate reported below high speed");
   a_iso_period_zero: assert property (@(posedge clock) disable iff (!rstn)
      build && xfer == ep_desc_pkg::XFER_ISO && interval > ep_desc_pkg::IVL_MAX_EXP
      |=> period_cyc == 32'h0000_0000)
      else $error("period given for bad isochronous interval");
   // check_done follows check_en one cycle later and is never raised without it
   a_check_pulse: assert property (@(posedge clock) disable iff (!rstn)
      check_en |=> check_done)
      else $error("check not answered");
   a_check_quiet: assert property (@(posedge clock) disable iff (!rstn)
      !check_en |=> !check_done)
      else $error("check answered without request");
   a_feedback_err: assert property (@(posedge clock) disable iff (!rstn)
      check_en && check_desc[25:24] == ep_desc_pkg::XFER_ISO &&
      check_desc[29:28] == ep_desc_pkg::USAGE_FEEDBACK &&
      check_desc[27:26] != ep_desc_pkg::SYNC_NONE |=> check_err)
      else $error("synchronized feedback endpoint not flagged");
   a_rsvd_mult_err: assert property (@(posedge clock) disable iff (!rstn)
      check_en && speed == 2'(ep_desc_pkg::SPEED_HIGH) && check_desc[24] &&
      check_desc[44:43] == ep_desc_pkg::MULT_RSVD |=> check_err)
      else $error("reserved transaction count not flagged");
   a_hs_intr_ivl: assert property (@(posedge clock) disable iff (!rstn)
      check_en && speed == 2'(ep_desc_pkg::SPEED_HIGH) &&
      check_desc[25:24] == ep_desc_pkg::XFER_INTR &&
      check_desc[55:48] > ep_desc_pkg::IVL_MAX_EXP |=> check_err)
      else $error("high speed interrupt interval not flagged");
   a_zero_not_stored: assert property (@(posedge clock) disable iff (!rstn)
      build && ep_num == 4'h0 |=> !wr_q)
      else $error("endpoint zero descriptor stored");
   a_addr_reserved: assert property (@(posedge clock) disable iff (!rstn)
      wr_q |-> wr_desc_q[22:20] == 3'h0)
      else $error("address reserved bits set");
   a_attr_nonios: assert property (@(posedge clock) disable iff (!rstn)
      wr_q && wr_desc_q[25:24] != ep_desc_pkg::XFER_ISO |-> wr_desc_q[29:26] == 4'h0)
      else $error("non isochronous attribute bits set");
   a_mps_top_zero: assert property (@(posedge clock) disable iff (!rstn)
      wr_q |-> wr_desc_q[47:45] == 3'h0)
      else $error("packet size reserved bits set");
   a_header_bytes: assert property (@(posedge clock) disable iff (!rstn)
      wr_q |-> wr_desc_q[15:0] == {ep_desc_pkg::DESC_TYPE_EP, ep_desc_pkg::DESC_LEN})
      else $error("length or type byte wrong");
   a_rsvd_usage_err: assert property (@(posedge clock) disable iff (!rstn)
      check_en && check_desc[25:24] == ep_desc_pkg::XFER_ISO &&
      check_desc[29:28] == ep_desc_pkg::USAGE_RSVD |=> check_err && check_done)
      else $error("reserved usage not flagged");
   a_iso_interval_err: assert property (@(posedge clock) disable iff (!rstn)
      check_en && check_desc[25:24] == ep_desc_pkg::XFER_ISO &&
      check_desc[55:48] > ep_desc_pkg::IVL_MAX_EXP |=> check_err)
      else $error("isochronous interval out of range not flagged");
   a_mult_two_err: assert property (@(posedge clock) disable iff (!rstn)
      check_en && speed == 2'(ep_desc_pkg::SPEED_HIGH) &&
      check_desc[25:24] == ep_desc_pkg::XFER_INTR &&
      check_desc[44:43] == ep_desc_pkg::MULT_TWO &&
      check_desc[42:32] < ep_desc_pkg::MPS_MIN_TWO |=> check_err)
      else $error("short packet size with two transactions not flagged");
endmodule // ep_desc_decoder

/* ep_desc_if.sv */
// byte stream carrier between the decoder and its descriptor store
`timescale 1ns/1ns
interface ep_desc_if;
   logic [2:0] addr;
   logic [7:0] rdata;
   modport ctrl (output addr, input rdata);
   modport store (input addr, output rdata);
endinterface // ep_desc_if

/* ep_desc_pkg.sv */
// constants and types shared by the endpoint descriptor block
package ep_desc_pkg;
   localparam logic [7:0] DESC_LEN = 8'h07; // descriptor length in bytes
   localparam logic [7:0] DESC_TYPE_EP = 8'h05; // endpoint descriptor type
   localparam logic [2:0] OFS_LEN = 3'h0;
   localparam logic [2:0] OFS_TYPE = 3'h1;
   localparam logic [2:0] OFS_ADDR = 3'h2;
   localparam logic [2:0] OFS_ATTR = 3'h3;
   localparam logic [2:0] OFS_MPS_LO = 3'h4;
   localparam logic [2:0] OFS_MPS_HI = 3'h5;
   localparam logic [2:0] OFS_INTERVAL = 3'h6;
   localparam logic [2:0] OFS_LAST = 3'h6;
   localparam logic [1:0] XFER_CONTROL = 2'h0;
   localparam logic [1:0] XFER_ISO = 2'h1;
   localparam logic [1:0] XFER_BULK = 2'h2;
   localparam logic [1:0] XFER_INTR = 2'h3;
   localparam logic [1:0] SYNC_NONE = 2'h0;
   localparam logic [1:0] USAGE_FEEDBACK = 2'h1;
   localparam logic [1:0] USAGE_RSVD = 2'h3;
   localparam logic [1:0] MULT_RSVD = 2'h3;
   localparam logic [1:0] MULT_TWO = 2'h1;
   localparam logic [1:0] MULT_THREE = 2'h2;
   localparam logic [10:0] MPS_MIN_TWO = 11'h201; // 513
   localparam logic [10:0] MPS_MIN_THREE = 11'h2ab; // 683
   localparam logic [10:0] MPS_MAX_HB = 11'h400; // 1024
   localparam logic [7:0] IVL_MAX_EXP = 8'h10; // 16
   localparam logic [7:0] IVL_MIN = 8'h01;
   localparam int FRAME_NS = 1000000; // full/low speed frame
   localparam int UFRAME_NS = 125000; // high speed microframe
   localparam int CLK_NS = 10;
   localparam int FRAME_CYC = FRAME_NS / CLK_NS;
   localparam int UFRAME_CYC = UFRAME_NS / CLK_NS;
   typedef enum logic [1:0] {SPEED_LOW, SPEED_FULL, SPEED_HIGH} speed_t;
endpackage

/* ep_desc_store.sv */
// seven-byte descriptor store with registered read data
`timescale 1ns/1ns
module ep_desc_store (
   input wire logic clock,
   input wire logic rstn,
   input wire logic wr_en,
   input wire logic [55:0] wr_desc,
   ep_desc_if.store port
);
   logic [7:0] mem_q [0:6];
   // whole descriptor is loaded at once
   always_ff @(posedge clock) begin
      if (!rstn) begin
         for (int i = 0; i < 7; i++) begin
            mem_q[i] <= 8'h00;
         end
      end else if (wr_en) begin
         for (int i = 0; i < 7; i++) begin
            mem_q[i] <= wr_desc[8*i +: 8];
         end
      end
   end
   // registered read port
   always_ff @(posedge clock) begin
      if (!rstn) begin
         port.rdata <= 8'h00;
      end else if (port.addr <= ep_desc_pkg::OFS_LAST) begin
         port.rdata <= mem_q[port.addr];
      end else begin
         port.rdata <= 8'h00;
      end
   end
endmodule // ep_desc_store

/* ep_host_model.sv */
// host model that reads one endpoint descriptor out of the configuration data
`timescale 1ns/1ns
module ep_host_model (
   input wire logic clock,
   input wire logic rstn,
   input wire logic go,
   output logic cfg_read,
   output logic [2:0] rd_ofs
);
   // ===========================================
   // read sequence
   // walk offsets 0..7 back to back; offset 7 lies past the descriptor
   always @(negedge clock) begin
      if (go && rstn) begin
         for (int i = 0; i < 8; i++) begin
            cfg_read <= 1'b1;
            rd_ofs <= i[2:0];
            @(negedge clock);
         end
         cfg_read <= 1'b0;
      end else begin
         cfg_read <= 1'b0;
         rd_ofs <= 3'($urandom); // idle offset keeps changing so it is never trusted
      end
   end
endmodule // ep_host_model
